// ### lpw_ctrl.sv
/*
 Wake and restart controller: latches interrupt events, decides halt entry, wake and vectoring.
 Assumes the sequencer raises one request at a time and sits at an instruction boundary.
*/
`timescale 1ns/100ps
module lpw_ctrl
  import lpw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lpw_req_t i_req,
  input wire logic i_nmi,
  input wire logic [LPW_NPIN-1:0] i_pin,
  input wire logic [LPW_NPIN-1:0] i_pin_ddr,
  input wire logic [LPW_NPIN-1:0] i_pin_or,
  input wire logic [LPW_NPIN-1:0] i_port_data_reg,
  input wire logic [LPW_NSRC-1:0] i_periph_evt,
  output lpw_dec_t o_dec,
  output lpw_state_t o_state,
  output lpw_level_t o_level,
  output logic o_core_halted,
  output logic o_global_irq_enable
);
  // Two synchroniser stages for pins and NMI, then one stage for edges
  logic [LPW_NPIN:0] sync1, sync2, last;
  logic [LPW_NPIN:0] next_sync1, next_sync2, next_last;

  // Global maskable enable
  logic global_irq_enable, next_gen;
  logic opt_write;

  // Latched requests
  logic [LPW_NSRC-1:0] pend, next_pend;
  logic nmi_pend, next_nmi_pend;

  // Sequencer view: level, saved level, run state and decisions
  lpw_level_t level, next_level, saved, next_saved;
  logic mask_nest, next_mask_nest;
  lpw_state_t state, next_state;
  lpw_dec_t dec, next_dec;
  logic halted, next_halted;
  logic halt_req, vec_mask, vec_nmi_go;
  logic [1:0] mask_idx;

  // Pin set to interrupt input by its direction, option and data bits
  function automatic logic pin_is_irq(input logic ddr, input logic opt, input logic dat);
    return ({ddr, opt, dat} == LPW_PIN_IRQ_CFG);
  endfunction : pin_is_irq

  // Lowest index wins among pending maskable sources
  function automatic logic [1:0] prio_idx(input logic [LPW_NSRC-1:0] p);
    logic [1:0] r;
    r = 2'h0;
    for (int k = LPW_NSRC - 1; k >= 0; k--) begin
      if (p[k]) begin
        r = k[1:0];
      end
    end
    return r;
  endfunction : prio_idx

  logic [LPW_NPIN-1:0] pin_fall, pin_cfg;
  logic pin_evt, nmi_rise, mask_ready, any_wake;

  // Synchroniser group
  always_comb begin
    next_sync1 = {i_nmi, i_pin};
    next_sync2 = sync1;
    next_last = sync2;
  end

  // Edge detection and wake qualification
  always_comb begin
    for (int k = 0; k < LPW_NPIN; k++) begin
      pin_cfg[k] = pin_is_irq(i_pin_ddr[k], i_pin_or[k], i_port_data_reg[k]);
    end
    pin_fall = last[LPW_NPIN-1:0] & ~sync2[LPW_NPIN-1:0];
    pin_evt = |(pin_fall & pin_cfg) & global_irq_enable;
    nmi_rise = sync2[LPW_NPIN] & ~last[LPW_NPIN];
    mask_ready = (pend != LPW_SRC_NONE) & global_irq_enable;
    // NMI wakes only with global enable set
    any_wake = mask_ready | (nmi_pend & global_irq_enable);
    mask_idx = prio_idx(pend);
  end

  // Enable group: writes are ignored while halted
  always_comb begin
    opt_write = (state == LPW_ST_RUN) && i_req.wr_en && (i_req.wr_addr == LPW_OPT_ADDR);
    next_gen = global_irq_enable;
    if (opt_write) begin
      next_gen = i_req.wr_data[LPW_GEN_BIT];
    end
  end

  // Pending group: new events win except on the maskable source being taken
  always_comb begin
    next_pend = pend | i_periph_evt;
    next_pend[0] = next_pend[0] | pin_evt;
    if (vec_mask) begin
      next_pend[mask_idx] = 1'b0;
    end
    next_nmi_pend = nmi_pend | nmi_rise;
    if (vec_nmi_go) begin
      next_nmi_pend = nmi_rise;
    end
  end

  // Sequencer group
  always_comb begin
    halt_req = i_req.halt_wait || i_req.halt_stop;
    next_level = level;
    next_saved = saved;
    next_mask_nest = mask_nest;
    next_state = state;
    next_dec = '0;
    vec_mask = 1'b0;
    vec_nmi_go = 1'b0;
    unique case (state)
      LPW_ST_RUN: begin
        if (halt_req) begin
          if (any_wake || (nmi_pend && level != LPW_LVL_NMI)) begin
            next_dec.halt_skip = 1'b1;
          end else begin
            next_saved = level;
            next_state = i_req.halt_stop ? LPW_ST_STOP : LPW_ST_WAIT;
          end
        end else if (i_req.reti) begin
          if (level == LPW_LVL_NMI) begin
            next_level = mask_nest ? LPW_LVL_MASK : LPW_LVL_MAIN;
            next_mask_nest = 1'b0;
          end else begin
            next_level = LPW_LVL_MAIN;
          end
        end else if (nmi_pend && level != LPW_LVL_NMI) begin
          // NMI serviced regardless of global enable
          vec_nmi_go = 1'b1;
          next_mask_nest = (level == LPW_LVL_MASK);
          next_level = LPW_LVL_NMI;
          next_dec.vec_take = 1'b1;
          next_dec.vec_nmi = 1'b1;
        end else if (mask_ready && level == LPW_LVL_MAIN) begin
          vec_mask = 1'b1;
          next_dec.vec_take = 1'b1;
          next_dec.vec_src = mask_idx;
          next_level = LPW_LVL_MASK;
        end
      end
      LPW_ST_WAIT, LPW_ST_STOP: begin
        if (any_wake) begin
          next_state = LPW_ST_RUN;
          unique case (saved)
            LPW_LVL_MAIN: begin
              next_dec.resume_next = 1'b0;
            end
            LPW_LVL_NMI: begin
              next_dec.resume_next = 1'b1;
            end
            LPW_LVL_MASK: begin
              next_dec.resume_next = ~(nmi_pend & global_irq_enable);
            end
            default: begin
              next_dec.resume_next = 1'b1;
            end
          endcase
        end
      end
      default: begin
        next_state = LPW_ST_RUN;
      end
    endcase
    next_halted = (next_state != LPW_ST_RUN);
  end

  // Synchroniser registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      last <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      last <= next_last;
    end
  end

  // Enable register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      global_irq_enable <= LPW_OPT_RESET[LPW_GEN_BIT];
    end else begin
      global_irq_enable <= next_gen;
    end
  end

  // Pending registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend <= LPW_SRC_NONE;
      nmi_pend <= 1'b0;
    end else begin
      pend <= next_pend;
      nmi_pend <= next_nmi_pend;
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level <= LPW_LVL_MAIN;
      saved <= LPW_LVL_MAIN;
      mask_nest <= 1'b0;
      state <= LPW_ST_RUN;
      dec <= '0;
      halted <= 1'b0;
    end else begin
      level <= next_level;
      saved <= next_saved;
      mask_nest <= next_mask_nest;
      state <= next_state;
      dec <= next_dec;
      halted <= next_halted;
    end
  end

  // Outputs straight from registers
  always_comb begin
    o_dec = dec;
    o_state = state;
    o_level = level;
    o_core_halted = halted;
    o_global_irq_enable = global_irq_enable;
  end
endmodule : lpw_ctrl

// ### lpw_ctrl_monitor.sv
/* Port checker for lpw_ctrl; assumes it is bound to each instance. */
`timescale 1ns/100ps
module lpw_ctrl_monitor import lpw_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lpw_req_t i_req,
  input wire lpw_dec_t o_dec,
  input wire lpw_state_t o_state,
  input wire lpw_level_t o_level,
  input wire logic o_core_halted,
  input wire logic o_global_irq_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_halt_decode: assert property (o_core_halted == (o_state != LPW_ST_RUN)
    && (!o_core_halted || o_dec == '0)) else $error("halt flag");
  a_nmi_resume: assert property ($fell(o_core_halted) && o_level == LPW_LVL_NMI
    |-> o_dec.resume_next) else $error("nmi resume");
  a_wait_entry: assert property (i_req.halt_wait && !o_core_halted
    |=> o_state == LPW_ST_WAIT || o_dec.halt_skip) else $error("wait entry");
  a_stop_entry: assert property (i_req.halt_stop && !o_core_halted
    |=> o_state == LPW_ST_STOP || o_dec.halt_skip) else $error("stop entry");
  a_enable_write: assert property (i_req.wr_en && i_req.wr_addr == LPW_OPT_ADDR
    && !o_core_halted |=> o_global_irq_enable == $past(i_req.wr_data[LPW_GEN_BIT]))
    else $error("enable write");
  a_nmi_nowake: assert property (o_core_halted && !o_global_irq_enable |=> o_core_halted)
    else $error("woke disabled");
  a_skip_cause: assert property (o_dec.halt_skip
    |-> $past(i_req.halt_wait || i_req.halt_stop)) else $error("stray skip");
  a_mask_resume: assert property ($fell(o_core_halted) && o_level == LPW_LVL_MASK
    |-> ##[0:1] (o_dec.resume_next || o_dec.vec_nmi)) else $error("mask resume");
  a_main_vector: assert property ($fell(o_core_halted) && o_level == LPW_LVL_MAIN
    |-> !o_dec.resume_next ##1 o_dec.vec_take) else $error("main resume");
endmodule : lpw_ctrl_monitor
bind lpw_ctrl lpw_ctrl_monitor mon (.*);

// ### lpw_pkg.sv
/*
 Package for the low-power wake and restart control block: levels, states, carriers.
 Assumes a sequencer that issues one-cycle requests and follows the returned decisions.
*/
package lpw_pkg;
  localparam logic [7:0] LPW_OPT_ADDR = 8'hC8;
  localparam int LPW_GEN_BIT = 4;
  localparam logic [7:0] LPW_OPT_RESET = 8'h00;
  localparam int LPW_NPIN = 8;
  localparam int LPW_NSRC = 4;
  localparam logic [LPW_NSRC-1:0] LPW_SRC_NONE = 4'h0;
  localparam logic [2:0] LPW_PIN_IRQ_CFG = 3'h2;

  typedef enum logic [1:0] {
    LPW_LVL_MAIN = 2'b00,
    LPW_LVL_MASK = 2'b01,
    LPW_LVL_NMI = 2'b10
  } lpw_level_t;

  typedef enum logic [1:0] {
    LPW_ST_RUN = 2'b00,
    LPW_ST_WAIT = 2'b01,
    LPW_ST_STOP = 2'b10
  } lpw_state_t;

  typedef struct packed {
    logic halt_wait;
    logic halt_stop;
    logic reti;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } lpw_req_t;

  typedef struct packed {
    logic vec_take;
    logic vec_nmi;
    logic [1:0] vec_src;
    logic resume_next;
    logic halt_skip;
  } lpw_dec_t;
endpackage : lpw_pkg

// ### lpw_src_model.sv
/* Sequencer and interrupt source model; assumes the bench clock. */
`timescale 1ns/100ps
module lpw_src_model import lpw_pkg::*; (
  input wire logic clk,
  output lpw_req_t req,
  output logic nmi,
  output logic [LPW_NPIN-1:0] pin,
  output logic [LPW_NSRC-1:0] evt
);
  initial begin
    req = '0;
    nmi = 1'b0;
    pin = '1;
    evt = '0;
  end
  task automatic op(input logic [3:0] f);
    @(negedge clk) req = {f, LPW_OPT_ADDR, 8'h10};
  endtask : op
  task automatic hit(input int k);
    repeat (6) @(negedge clk);
    if (k == 0) nmi = 1'b1;
    else if (k == 1) pin[0] = 1'b0;
    else evt[0] = 1'b1;
    fork
      begin
        @(negedge clk) evt = '0;
        repeat (4) @(negedge clk);
        nmi = 1'b0;
        pin = '1;
      end
    join_none
  endtask : hit
endmodule : lpw_src_model

// ### test_lpw_ctrl.sv
/* Bench for lpw_ctrl; assumes lpw_src_model drives requests and events. */
`timescale 1ns/100ps
module test_lpw_ctrl import lpw_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  lpw_req_t req;
  logic nmi, hlt, gen;
  logic [7:0] pin;
  logic [7:0] pin_ddr = 8'h00;
  logic [7:0] pin_opt = 8'hFF;
  logic [7:0] pin_data = 8'h00;
  logic [3:0] evt;
  lpw_dec_t dec;
  lpw_state_t st;
  lpw_level_t lvl;
  lpw_src_model m (.clk(clk), .req(req), .nmi(nmi), .pin(pin), .evt(evt));
  lpw_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_nmi(nmi), .i_pin(pin),
    .i_pin_ddr(pin_ddr), .i_pin_or(pin_opt), .i_port_data_reg(pin_data), .i_periph_evt(evt),
    .o_dec(dec), .o_state(st), .o_level(lvl), .o_core_halted(hlt), .o_global_irq_enable(gen));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rst();
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("enable", 8'h00, gen);
  endtask : rst
  task automatic wk(input logic [7:0] rn);
    for (int i = 0; i < 20 && hlt !== 1'b0; i++) @(negedge clk);
    chk("resume", rn, dec.resume_next);
  endtask : wk
  task automatic s_nmi();
    m.op(4'h8);
    m.op(4'h0);
    m.hit(0);
    repeat (8) @(negedge clk);
    chk("halted", 8'h01, hlt);
  endtask : s_nmi
  task automatic s_skip();
    m.hit(2);
    m.op(4'h1);
    m.op(4'h8);
    m.op(4'h0);
    chk("skip", 8'h01, dec.halt_skip);
    @(negedge clk) chk("vector", 8'h01, dec.vec_take);
    chk("source", 8'h00, dec.vec_src);
  endtask : s_skip
  task automatic s_cfg();
    pin_data = 8'hFF;
    m.op(4'h1);
    m.op(4'h8);
    m.op(4'h0);
    m.hit(1);
    repeat (8) @(negedge clk);
    chk("masked pin", 8'h01, hlt);
    pin_data = 8'h00;
  endtask : s_cfg
  task automatic s_nest();
    m.op(4'h1);
    m.hit(2);
    m.op(4'h0);
    repeat (3) @(negedge clk);
    chk("level", 8'(LPW_LVL_MASK), 8'(lvl));
    m.op(4'h8);
    m.op(4'h0);
    m.hit(0);
    wk(8'h00);
    @(negedge clk) chk("nmi", 8'h01, dec.vec_nmi);
    m.op(4'h8);
    m.op(4'h0);
    m.hit(2);
    wk(8'h01);
    chk("level", 8'(LPW_LVL_NMI), 8'(lvl));
  endtask : s_nest
  task automatic s_mask();
    m.op(4'h8);
    m.op(4'h0);
    m.hit(2);
    wk(8'h01);
    chk("level", 8'(LPW_LVL_MASK), 8'(lvl));
  endtask : s_mask
  task automatic s_stop();
    m.op(4'h1);
    m.op(4'h4);
    m.op(4'h0);
    chk("state", 8'(LPW_ST_STOP), 8'(st));
    m.hit(1);
    wk(8'h00);
  endtask : s_stop
  initial begin
    rst();
    s_nmi();
    rst();
    s_skip();
    s_mask();
    rst();
    s_stop();
    rst();
    s_cfg();
    rst();
    s_nest();
    end_sim();
  end
endmodule : test_lpw_ctrl
